// ==== core/rcfr_pkg.sv ====
/*
 * Constants for the communication register group: offsets, field positions,
 * reset values, preset lengths, command codes and FIFO marks.
 * Assumes a 6-bit register address from the serial host decoder.
 */
package rcfr_pkg;
	// ==========================================
	// Register map
	localparam int          ADDR_W        = 6;
	localparam int          DATA_W        = 8;
	localparam logic [5:0]  ADDR_STATE    = 6'h39;
	localparam logic [5:0]  ADDR_RXLEN_HI = 6'h3a;
	localparam logic [5:0]  ADDR_RXLEN_LO = 6'h3b;
	localparam logic [5:0]  ADDR_TX_SETUP = 6'h3c;
	localparam logic [5:0]  ADDR_FIFO     = 6'h3f;
	localparam logic [7:0]  RST_RXLEN_HI  = 8'h00;
	localparam logic [7:0]  RST_RXLEN_LO  = 8'h00;
	localparam logic [7:0]  RST_TX_SETUP  = 8'h00;
	// ==========================================
	// Field positions
	localparam int ST_TX_ACT    = 7;
	localparam int ST_RX_ACT    = 6;
	localparam int ST_OVFL      = 5;
	localparam int HI_SKIP_CRC  = 7;
	localparam int HI_RAW_FIFO  = 6;
	localparam int HI_REPEAT    = 5;
	localparam int HI_AUTO_ERR  = 4;
	localparam int TS_CRC5      = 3;
	localparam int TS_FORCE_CAL = 2;
	localparam int TS_S1        = 1;
	localparam int TS_S0        = 0;
	// ==========================================
	// Lengths, commands, FIFO marks
	localparam logic [11:0] LEN_SHORT     = 12'h010;
	localparam logic [11:0] LEN_LONG      = 12'h020;
	localparam logic [11:0] LEN_ERR       = 12'h029;
	localparam logic [7:0]  CMD_TX_CRC    = 8'h90;
	localparam logic [7:0]  CMD_TX_NOCRC  = 8'h91;
	localparam logic [7:0]  CMD_QUERY     = 8'h98;
	localparam logic [7:0]  CMD_SHORT_END = 8'h9c;
	localparam logic [7:0]  CMD_LONG      = 8'h9f;
	localparam int          FIFO_DEPTH    = 32;
	localparam int          CNT_W         = 6;
	localparam logic [5:0]  FIFO_CAP      = 6'h18;
	localparam logic [5:0]  LOW_MARK      = 6'h06;
	localparam logic [5:0]  HIGH_MARK     = 6'h12;
	localparam logic [4:0]  EMPTY_CODE    = 5'h1f;
	localparam logic [2:0]  BYTE_2ND      = 3'h2;
	localparam logic [2:0]  BYTE_4TH      = 3'h4;
	localparam logic [2:0]  BYTE_6TH      = 3'h6;

	typedef enum logic [1:0] {
		RCFR_IDLE = 2'b00,
		RCFR_TX   = 2'b01,
		RCFR_RX   = 2'b10
	} rcfr_phase_t;
endpackage

// ==== core/rcfr_stream_if.sv ====
/*
 * Byte stream carrier between the register group and its FIFOs.
 * Assumes one clock; a beat moves when valid and ready are both high.
 */
`timescale 1ns/1ps
interface rcfr_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ==== core/rcfr_fifo.sv ====
/*
 * Circular byte buffer with valid/ready on both sides and an occupancy count.
 * Assumes core_clk domain only; DEPTH must be a power of two.
 */
`timescale 1ns/1ps
module rcfr_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	rcfr_stream_if.snk                      wr,
	rcfr_stream_if.src                      rd,
	output      logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("rcfr_fifo: DEPTH must be a power of two");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	wire           push = wr.valid && wr.ready;
	wire           pop  = rd.valid && rd.ready;

	assign wr.ready = (cnt_r != CW'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem[rp_r];
	assign count    = cnt_r;

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wp_r] <= wr.data;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_r + AW'(push);
			rp_r  <= rp_r + AW'(pop);
			cnt_r <= cnt_r + CW'(push) - CW'(pop);
		end
	end
endmodule

// ==== core/rcfr_regs.sv ====
/*
 * Communication register group: FIFO status, reception length and control,
 * transmit frame setup, FIFO data port, and the two byte FIFOs.
 * Assumes the serial host decoder, command decoder and framer share core_clk.
 */
`timescale 1ns/1ps
module rcfr_regs
	import rcfr_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        rst_b,
	input  wire logic [rcfr_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [rcfr_pkg::DATA_W-1:0] reg_wdata,
	output      logic [rcfr_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        cmd_valid,
	input  wire logic [7:0]                  cmd_code,
	input  wire logic                        tx_busy,
	input  wire logic                        rx_busy,
	input  wire logic                        rx_header_valid,
	input  wire logic                        rx_header_bit,
	input  wire logic [7:0]                  rx_data,
	input  wire logic                        rx_valid,
	output      logic                        rx_ready,
	output      logic [7:0]                  tx_data,
	output      logic                        tx_valid,
	input  wire logic                        tx_ready,
	output      logic [11:0]                 rx_expected_len,
	output      logic                        rx_skip_crc_once,
	output      logic                        rx_raw_fifo,
	output      logic                        tx_short_crc_select,
	output      logic                        insert_calibration,
	output      logic [1:0]                  session_value,
	output      logic                        header_irq,
	output      logic                        second_byte_irq,
	output      logic                        fifo_level_irq
);
	import rcfr_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic is_short_cmd(input logic [7:0] c);
		return (c >= CMD_QUERY) && (c <= CMD_SHORT_END);
	endfunction

	function automatic logic hit(input logic [5:0] a, input logic [5:0] ref_a);
		return a == ref_a;
	endfunction

	// ==========================================
	// State
	logic [7:0]       rxlen_hi_r;
	logic [7:0]       rxlen_lo_r;
	logic [7:0]       tx_setup_r;
	logic             ovfl_r;
	logic             empty_rd_r;
	logic             rx_busy_d_r;
	logic             lvl_d_r;
	logic             cal_r;
	logic [2:0]       rx_bytes_r;
	logic [7:0]       rdata_r;
	rcfr_phase_t      phase_r;
	rcfr_phase_t      phase_nxt;
	logic [CNT_W-1:0] tx_cnt;
	logic [CNT_W-1:0] rx_cnt;

	rcfr_stream_if #(.W(8)) txw ();
	rcfr_stream_if #(.W(8)) txr ();
	rcfr_stream_if #(.W(8)) rxw ();
	rcfr_stream_if #(.W(8)) rxr ();

	// ==========================================
	// Decode
	wire wr_hi    = reg_wr && hit(reg_addr, ADDR_RXLEN_HI);
	wire wr_lo    = reg_wr && hit(reg_addr, ADDR_RXLEN_LO);
	wire wr_setup = reg_wr && hit(reg_addr, ADDR_TX_SETUP);
	wire wr_fifo  = reg_wr && hit(reg_addr, ADDR_FIFO);
	wire rd_fifo  = reg_rd && hit(reg_addr, ADDR_FIFO);
	// Edges of rx_busy restart the byte counter and end the skip-CRC frame
	wire rx_end   = rx_busy_d_r && !rx_busy;
	wire rx_start = rx_busy && !rx_busy_d_r;

	wire cmd_short = cmd_valid && is_short_cmd(cmd_code);
	wire cmd_long  = cmd_valid && (cmd_code == CMD_LONG);
	wire cmd_query = cmd_valid && (cmd_code == CMD_QUERY);
	wire cmd_data  = cmd_valid && (cmd_code == CMD_TX_CRC || cmd_code == CMD_TX_NOCRC);
	wire hdr_one   = rx_header_valid && rx_header_bit;
	wire auto_err  = hdr_one && rxlen_hi_r[HI_AUTO_ERR];

	// ==========================================
	// FIFOs
	// Capacity is held at 24 inside a 32-deep buffer, so late pushes are counted as overflow
	wire tx_full  = tx_cnt >= FIFO_CAP;
	wire rx_full  = rx_cnt >= FIFO_CAP;
	wire tx_push  = wr_fifo && !tx_full;
	wire rx_push  = rx_valid && rxw.ready && !rx_full;
	wire rx_pop   = rd_fifo && rxr.valid;
	wire ovfl_set = (wr_fifo && tx_full) || (rx_valid && rx_full);

	assign txw.data  = reg_wdata;
	assign txw.valid = tx_push;
	assign rxw.data  = rx_data;
	assign rxw.valid = rx_push;
	assign rx_ready  = rxw.ready && !rx_full;
	assign tx_data   = txr.data;
	assign tx_valid  = txr.valid;
	assign txr.ready = tx_ready;
	assign rxr.ready = rd_fifo;

	rcfr_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr       (txw),
		.rd       (txr),
		.count    (tx_cnt)
	);

	rcfr_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr       (rxw),
		.rd       (rxr),
		.count    (rx_cnt)
	);

	// ==========================================
	// Phase, which FIFO the byte count reports
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			RCFR_IDLE: begin
				if (rx_busy)
					phase_nxt = RCFR_RX;
				else if (tx_busy || tx_push)
					phase_nxt = RCFR_TX;
			end
			RCFR_TX: begin
				if (rx_busy)
					phase_nxt = RCFR_RX;
			end
			RCFR_RX: begin
				// Received bytes stay visible until the host loads the transmit FIFO or tx_busy rises
				if (tx_push || tx_busy)
					phase_nxt = RCFR_TX;
			end
			default: phase_nxt = RCFR_IDLE;
		endcase
	end

	wire [CNT_W-1:0] sel_cnt = (phase_r == RCFR_RX) ? rx_cnt : tx_cnt;
	wire [4:0] fb_field = empty_rd_r ? EMPTY_CODE : sel_cnt[4:0];

	wire [7:0] status_w = {tx_busy, rx_busy, ovfl_r, fb_field};

	// ==========================================
	// Read path
	wire [7:0] rd_mux =
		hit(reg_addr, ADDR_STATE)    ? status_w   :
		hit(reg_addr, ADDR_RXLEN_HI) ? rxlen_hi_r :
		hit(reg_addr, ADDR_RXLEN_LO) ? rxlen_lo_r :
		hit(reg_addr, ADDR_TX_SETUP) ? tx_setup_r :
		hit(reg_addr, ADDR_FIFO)     ? rxr.data   : 8'h00;

	assign reg_rdata = rdata_r;

	// ==========================================
	// Length presets; host write wins over a same-cycle preset
	wire       preset   = cmd_short || cmd_long || auto_err;
	wire [11:0] pre_len = cmd_short ? LEN_SHORT :
		cmd_long ? LEN_LONG : LEN_ERR;

	// Skip-CRC drops after the frame even when a preset lands in that cycle
	wire [7:0] hi_keep_w = rx_end ?
		(rxlen_hi_r & ~(8'h01 << HI_SKIP_CRC)) : rxlen_hi_r;
	wire [7:0] hi_nxt_w = wr_hi ? reg_wdata :
		preset ? {hi_keep_w[7:4], pre_len[11:8]} : hi_keep_w;
	wire [7:0] lo_nxt_w = wr_lo ? reg_wdata : preset ? pre_len[7:0] : rxlen_lo_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxlen_hi_r <= RST_RXLEN_HI;
			rxlen_lo_r <= RST_RXLEN_LO;
			tx_setup_r <= RST_TX_SETUP;
		end else begin
			rxlen_hi_r <= hi_nxt_w;
			rxlen_lo_r <= lo_nxt_w;
			if (wr_setup)
				tx_setup_r <= reg_wdata;
		end
	end

	// ==========================================
	// Status flags and events
	wire [2:0] bytes_nxt = rx_start ? 3'h0 :
		(rx_push && rx_bytes_r != 3'h7) ? rx_bytes_r + 3'h1 : rx_bytes_r;
	wire lvl_w = (tx_busy && tx_cnt < LOW_MARK) || (rx_busy && rx_cnt > HIGH_MARK);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovfl_r      <= 1'b0;
			empty_rd_r  <= 1'b0;
			rx_busy_d_r <= 1'b0;
			lvl_d_r     <= 1'b0;
			rx_bytes_r  <= 3'h0;
			cal_r       <= 1'b0;
			rdata_r     <= 8'h00;
			phase_r     <= RCFR_IDLE;
		end else begin
			// Set wins over the clear taken with a new command
			ovfl_r      <= ovfl_set || (ovfl_r && !cmd_valid);
			// Empty-read code stays until a byte enters either FIFO
			empty_rd_r  <= (rd_fifo && !rxr.valid) || (empty_rd_r && !tx_push && !rx_push);
			rx_busy_d_r <= rx_busy;
			lvl_d_r     <= lvl_w;
			rx_bytes_r  <= bytes_nxt;
			phase_r     <= phase_nxt;
			// Latched per command so the choice holds through the whole frame
			if (cmd_valid)
				cal_r <= cmd_query ||
					(cmd_data && tx_setup_r[TS_FORCE_CAL]);
			if (reg_rd)
				rdata_r <= rd_mux;
		end
	end

	// ==========================================
	// Outputs to the framer
	wire raw_mode = rxlen_hi_r[HI_RAW_FIFO];
	wire rep_hit  = rxlen_hi_r[HI_REPEAT] && (bytes_nxt == BYTE_4TH || bytes_nxt == BYTE_6TH);

	assign rx_expected_len     = {rxlen_hi_r[3:0], rxlen_lo_r};
	assign rx_skip_crc_once    = rxlen_hi_r[HI_SKIP_CRC];
	assign rx_raw_fifo         = raw_mode;
	assign tx_short_crc_select = tx_setup_r[TS_CRC5];
	assign insert_calibration  = cal_r;
	assign session_value       = {tx_setup_r[TS_S1], tx_setup_r[TS_S0]};
	assign header_irq          = hdr_one && !raw_mode;
	// Repeat bit is read live, so a host clear mid-frame stops later pulses
	assign second_byte_irq     = raw_mode && rx_push &&
		(bytes_nxt == BYTE_2ND || rep_hit);
	assign fifo_level_irq      = lvl_w && !lvl_d_r;

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	tx_flag_a: assert property (reg_rd && reg_addr == ADDR_STATE
		|=> reg_rdata[ST_TX_ACT] == $past(tx_busy))
		else $error("transmit flag wrong");
	rx_flag_a: assert property (reg_rd && reg_addr == ADDR_STATE
		|=> reg_rdata[ST_RX_ACT] == $past(rx_busy))
		else $error("receive flag wrong");
	ovfl_set_a: assert property (wr_fifo && tx_cnt == FIFO_CAP && !tx_ready
		|=> ovfl_r && tx_cnt == FIFO_CAP)
		else $error("overflow not flagged");
	count_show_a: assert property (reg_rd && reg_addr == ADDR_STATE
		&& !empty_rd_r && phase_r == RCFR_RX |=> reg_rdata[4:0] == $past(rx_cnt[4:0]))
		else $error("byte count wrong");
	empty_code_a: assert property (rd_fifo && rx_cnt == '0 ##1 !tx_push && !rx_push
		|=> fb_field == EMPTY_CODE)
		else $error("empty read code missing");
	crc_once_a: assert property (rx_end && !wr_hi |=> !rx_skip_crc_once)
		else $error("skip crc kept past frame");
	raw_swap_a: assert property (header_irq ==
		(rx_header_valid && rx_header_bit && !rx_raw_fifo))
		else $error("header irq in raw mode");
	repeat_a: assert property (second_byte_irq && bytes_nxt != BYTE_2ND
		|-> rxlen_hi_r[HI_REPEAT] && (rx_bytes_r == 3'h3 || rx_bytes_r == 3'h5))
		else $error("repeat irq without enable");
	err_len_a: assert property (auto_err && !cmd_valid && !wr_hi && !wr_lo
		|=> rx_expected_len == LEN_ERR)
		else $error("error length not preset");
	short_len_a: assert property (cmd_short && !wr_hi && !wr_lo
		|=> rx_expected_len == LEN_SHORT
		##1 (rx_expected_len == LEN_SHORT || $past(preset) || $past(wr_hi) || $past(wr_lo)))
		else $error("short length not preset");
	long_len_a: assert property (cmd_long && !wr_hi && !wr_lo
		|=> rx_expected_len == LEN_LONG)
		else $error("long length not preset");
	cal_a: assert property (cmd_valid |=> insert_calibration ==
		($past(cmd_query) || ($past(cmd_data) && $past(tx_setup_r[TS_FORCE_CAL]))))
		else $error("calibration choice wrong");
	cap_a: assert property (tx_cnt <= FIFO_CAP && rx_cnt <= FIFO_CAP)
		else $error("fifo above capacity");
	level_a: assert property (fifo_level_irq |=> !fifo_level_irq)
		else $error("level irq not a pulse");

	// Stream, setup and flag checks
	rx_take_a: assert property (rx_valid && rx_ready && !rx_pop
		|=> rx_cnt == $past(rx_cnt) + 6'h01)
		else $error("receive byte not stored");
	tx_pop_a: assert property (tx_valid && tx_ready && !tx_push
		|=> tx_cnt == $past(tx_cnt) - 6'h01)
		else $error("transmit byte not removed");
	count_tx_a: assert property (reg_rd && reg_addr == ADDR_STATE
		&& !empty_rd_r && phase_r != RCFR_RX |=> reg_rdata[4:0] == $past(tx_cnt[4:0]))
		else $error("transmit byte count wrong");
	ovfl_clear_a: assert property (ovfl_r && cmd_valid && !ovfl_set
		|=> !ovfl_r)
		else $error("overflow not cleared by command");
	empty_clear_a: assert property (empty_rd_r && rx_push && !rd_fifo
		|=> fb_field != EMPTY_CODE)
		else $error("empty code kept after new byte");
	skip_hold_a: assert property (rx_skip_crc_once && !rx_end && !wr_hi
		|=> rx_skip_crc_once)
		else $error("skip crc lost inside frame");
	second_irq_a: assert property (rx_push && raw_mode && rx_bytes_r == 3'h1
		&& !rx_start |-> second_byte_irq)
		else $error("second byte irq missing");
	rep_stop_a: assert property (rx_push && !rxlen_hi_r[HI_REPEAT]
		&& bytes_nxt != BYTE_2ND |-> !second_byte_irq)
		else $error("repeat irq after host clear");
	setup_copy_a: assert property (wr_setup
		|=> session_value == $past(reg_wdata[1:0])
		&& tx_short_crc_select == $past(reg_wdata[TS_CRC5]))
		else $error("transmit setup not applied");
	level_rise_a: assert property (tx_busy && tx_cnt < LOW_MARK && !lvl_d_r
		|-> fifo_level_irq)
		else $error("level irq missing in transmit");

	second_cov: cover property (second_byte_irq ##[1:40] second_byte_irq);
	ovfl_cov: cover property (rx_valid && rx_full);
	err_cov: cover property (auto_err ##1 rx_busy);
	query_cov: cover property (cmd_query ##1 tx_busy);
	rep_cov: cover property (second_byte_irq && rx_bytes_r == 3'h5);
endmodule

// ==== tb/rcfr_framer_model.sv ====
/*
 * Framer model: receive byte source, transmit byte sink, header strobe.
 * Assumes it shares core_clk with the register group.
 */
`timescale 1ns/1ps
module rcfr_framer_model (
	input  wire logic       core_clk,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output      logic       tx_busy,
	output      logic       rx_busy,
	output      logic       rx_header_valid,
	output      logic       rx_header_bit,
	output      logic [7:0] rx_data,
	output      logic       rx_valid,
	output      logic       tx_ready
);
	logic [7:0] got_q[$];
	bit         ok;

	initial begin
		{tx_busy, rx_busy, rx_header_valid, rx_header_bit, rx_valid, tx_ready} = '0;
		rx_data = 8'h00;
	end

	// ==========================================
	// Header strobe, one cycle wide
	task automatic header(input logic b);
		@(posedge core_clk);
		rx_header_valid <= 1'b1;
		rx_header_bit   <= b;
		@(posedge core_clk);
		rx_header_valid <= 1'b0;
		rx_header_bit   <= ~b;
	endtask

	// ==========================================
	// Receive frame; each byte held until an edge sees ready high
	task automatic rx_frame(input int n, input logic [7:0] base);
		@(posedge core_clk);
		rx_busy <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			rx_data  <= base + i[7:0];
			rx_valid <= 1'b1;
			do begin
				#1 ok = rx_ready;
				@(posedge core_clk);
			end while (!ok);
		end
		// Released data line must not keep the last byte
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
		rx_busy  <= 1'b0;
	endtask

	// ==========================================
	// Transmit sink; slow mode stalls every other cycle
	task automatic tx_take(input int n, input bit slow);
		got_q.delete();
		@(posedge core_clk);
		tx_busy <= 1'b1;
		for (int k = 0; k < 400 && got_q.size() < n; k++) begin
			@(posedge core_clk);
			tx_ready <= !slow || k[0];
			#1;
			if (tx_ready && tx_valid) begin
				got_q.push_back(tx_data);
			end
		end
		@(posedge core_clk);
		tx_ready <= 1'b0;
		tx_busy  <= 1'b0;
	endtask
endmodule

// ==== tb/rfid_comm_fifo_framing_regs_bench.sv ====
/*
 * Self-checking bench for the communication register group.
 * Assumes the framer model on the stream side and host strobes on core_clk.
 */
`timescale 1ns/1ps
module rfid_comm_fifo_framing_regs_bench;
	import rcfr_pkg::*;
	logic        core_clk;
	logic        rst_b;
	logic [5:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic        tx_busy, rx_busy, rx_header_valid, rx_header_bit;
	logic [7:0]  rx_data, tx_data;
	logic        rx_valid, rx_ready, tx_valid, tx_ready;
	logic [11:0] rx_expected_len;
	logic        rx_skip_crc_once, rx_raw_fifo, tx_short_crc_select, insert_calibration;
	logic [1:0]  session_value;
	logic        header_irq, second_byte_irq, fifo_level_irq;
	logic [7:0]  v;
	int          error_cnt, check_count, cyc, irq2_n, hdr_n, lvl_n;

	rcfr_regs u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_busy(tx_busy), .rx_busy(rx_busy),
		.rx_header_valid(rx_header_valid), .rx_header_bit(rx_header_bit),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_expected_len(rx_expected_len),
		.rx_skip_crc_once(rx_skip_crc_once), .rx_raw_fifo(rx_raw_fifo),
		.tx_short_crc_select(tx_short_crc_select), .insert_calibration(insert_calibration),
		.session_value(session_value), .header_irq(header_irq),
		.second_byte_irq(second_byte_irq), .fifo_level_irq(fifo_level_irq));

	rcfr_framer_model u_far (.core_clk(core_clk), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_busy(tx_busy), .rx_busy(rx_busy),
		.rx_header_valid(rx_header_valid), .rx_header_bit(rx_header_bit),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));

	// ==========================================
	// Clock, pulse counters, hang guard
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (second_byte_irq === 1'b1) irq2_n++;
		if (header_irq === 1'b1) hdr_n++;
		if (fifo_level_irq === 1'b1) lvl_n++;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	// ==========================================
	// Host access tasks
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(posedge core_clk);
		#1 d = reg_rdata;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic cmd(input logic [7:0] c);
		@(posedge core_clk);
		cmd_code  <= c;
		cmd_valid <= 1'b1;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		{rst_b, reg_addr, reg_wr, reg_rd, reg_wdata, cmd_valid, cmd_code} = '0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		rdc(ADDR_RXLEN_HI, 8'h00);
		rdc(ADDR_RXLEN_LO, 8'h00);
		rdc(ADDR_TX_SETUP, 8'h00);
		rdc(ADDR_STATE, 8'h00);
		rdc(6'h20, 8'h00);
		wr(ADDR_RXLEN_HI, 8'h05);
		wr(ADDR_RXLEN_LO, 8'ha7);
		@(posedge core_clk);
		#1 chk(rx_expected_len, 12'h5a7);
		for (int c = 'h98; c <= 'h9c; c++) begin
			wr(ADDR_RXLEN_LO, 8'h77);
			cmd(c[7:0]);
			chk(rx_expected_len, 12'd16);
		end
		cmd(8'h9f);
		chk(rx_expected_len, 12'd32);
		rdc(ADDR_RXLEN_LO, 8'h20);
		// Setup: short CRC, no forced calibration, session 2
		wr(ADDR_TX_SETUP, 8'h0a);
		cmd(8'h98);
		chk(insert_calibration, 1'b1);
		chk(session_value, 2'h2);
		chk(tx_short_crc_select, 1'b1);
		cmd(8'h90);
		chk(insert_calibration, 1'b0);
		wr(ADDR_TX_SETUP, 8'h05);
		cmd(8'h91);
		chk(insert_calibration, 1'b1);
		chk(session_value, 2'h1);
		chk(tx_short_crc_select, 1'b0);
		rdc(ADDR_TX_SETUP, 8'h05);
		// Error reply preset from header bit
		wr(ADDR_RXLEN_HI, 8'h10);
		wr(ADDR_RXLEN_LO, 8'h08);
		u_far.header(1'b1);
		@(posedge core_clk);
		#1 chk(rx_expected_len, 12'd41);
		// Transmit FIFO: one load past capacity, then slow drain
		for (int i = 0; i < 25; i++) begin
			wr(ADDR_FIFO, 8'h40 + i[7:0]);
		end
		rdc(ADDR_STATE, 8'h38);
		fork
			u_far.tx_take(24, 1'b1);
			begin
				repeat (4) @(posedge core_clk);
				rd(ADDR_STATE, v);
				chk(v[7], 1'b1);
			end
		join
		chk(u_far.got_q.size(), 12'd24);
		for (int i = 0; i < 24; i++) begin
			chk(u_far.got_q[i], 8'h40 + i[7:0]);
		end
		chk(lvl_n, 12'd1);
		rdc(ADDR_STATE, 8'h20);
		// Receive in raw mode with repeat interrupts and skip-CRC
		cmd(8'h9f);
		wr(ADDR_RXLEN_HI, 8'he0);
		@(posedge core_clk);
		#1 chk(rx_skip_crc_once, 1'b1);
		chk(rx_raw_fifo, 1'b1);
		u_far.header(1'b1);
		fork
			u_far.rx_frame(6, 8'hc0);
			begin
				repeat (2) @(posedge core_clk);
				rd(ADDR_STATE, v);
				chk(v[6], 1'b1);
			end
		join
		#1 chk(irq2_n, 12'd3);
		chk(hdr_n, 12'd1);
		repeat (2) @(posedge core_clk);
		#1 chk(rx_skip_crc_once, 1'b0);
		rdc(ADDR_STATE, 8'h06);
		for (int i = 0; i < 6; i++) begin
			rdc(ADDR_FIFO, 8'hc0 + i[7:0]);
		end
		rd(ADDR_FIFO, v);
		rdc(ADDR_STATE, 8'h1f);
		// Raw mode without repeat: only the second byte raises its pulse
		wr(ADDR_RXLEN_HI, 8'h40);
		u_far.rx_frame(4, 8'hd0);
		#1 chk(irq2_n, 12'd4);
		rdc(ADDR_STATE, 8'h04);
		final_report();
	end
endmodule
